/* core/pps_supervisor.sv */
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
// Functional notes
// R01: gate starts after line above brown-in 100 us and supply reached startup.
// R02: line below brown-out continuously 50 ms turns gate off and shuts down.
// R03: after brown-out, gate stays off until line rises above brown-in again.
// R04: aux winding sampled a fixed delay after each gate fall, against OV/UV.
// R05: OV or UV threshold met 7 consecutive cycles trips its fault.
// R06: OV/UV fault shuts down until supply undervoltage lockout.
// R07: undervoltage comparison ignored during a startup blank time.
// R08: external input sampled after gate fall; high 7 cycles trips fault.
// R09: external low check uses the sample about 100 ns before gate fall.
// R10: external low fault only after 32 ms of low samples.
// R11: either external fault stops gate until supply lockout.
// R12: current sense at fast threshold 7 consecutive cycles stops switching.
// R13: sense-short sample taken 4 us after each gate rise.
// R14: sense below short threshold 7 consecutive cycles disables gate.
// R15: overcurrent and sense-short faults restart only after supply lockout.
// R16: over-temperature blocks switching while active, releases when clear.
// R17: no new gate pulses while feedback below 1.2 V.
// R18: supply at maintain threshold enables high charging current.
// R19: 250 ns leading-edge blanking from each gate turn-on.
// R20: during blanking, limit and PWM comparators ignored, pulse not ended.
// R21: consecutive counters clear on any cycle whose sample misses.
// R22: latched faults cleared only by supply lockout; lockout also clears all timers and counters.
module pps_supervisor #(
  parameter int BRIN_CYC  = pps_pkg::BRIN_CYC,
  parameter int BROUT_CYC = pps_pkg::BROUT_CYC,
  parameter int EXTL_CYC  = pps_pkg::EXTL_CYC,
  parameter int UVB_CYC   = pps_pkg::UVB_CYC,
  parameter int PERIOD    = pps_pkg::PERIOD_CYC,
  parameter int MAXON     = pps_pkg::MAXON_CYC
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_nrst,
  input  wire logic                      i_line_above_brin,
  input  wire logic                      i_line_below_brout,
  input  wire logic                      i_vcc_above_start,
  input  wire logic                      i_vcc_below_supply_undervoltage_lockout,
  input  wire logic                      i_vcc_below_maint,
  input  wire logic                      i_aux_above_ov,
  input  wire logic                      i_aux_below_uv,
  input  wire logic                      i_ext_above_high,
  input  wire logic                      i_ext_below_low,
  input  wire logic                      i_cs_above_fast_overcurrent_fault,
  input  wire logic                      i_cs_below_sense_short_fault,
  input  wire logic                      i_cs_above_limit,
  input  wire logic                      i_pwm_cmp_trip,
  input  wire logic                      i_fb_below_min,
  input  wire logic                      i_otp_hot,
  input  wire logic                      i_wb_cyc,
  input  wire logic                      i_wb_stb,
  input  wire logic                      i_wb_we,
  input  wire logic [pps_pkg::ADR_W-1:0] i_wb_adr,
  input  wire logic [3:0]                i_wb_sel,
  input  wire logic [31:0]               i_wb_dat,
  output logic [31:0]                    o_wb_dat,
  output logic                           o_wb_ack,
  output logic                           o_gate,
  output logic                           o_vcc_charge_hi
);
  import pps_pkg::*;

  localparam int TW = $clog2(BROUT_CYC + EXTL_CYC + BRIN_CYC + UVB_CYC + 2);
  localparam int PW = $clog2(PERIOD + 1);

  generate
    if (MAXON >= PERIOD || MAXON <= LEB_CYC || SENSE_SHORT_FAULT_CYC >= PERIOD ||
        TSMP_CYC >= PERIOD || PRE_FALL_CYC < 1 || BRIN_CYC < 1 ||
        BROUT_CYC < 1 || EXTL_CYC < 1 || UVB_CYC < 1) begin : g_chk
      $error("pps_supervisor: timing parameters out of range");
    end
  endgenerate

  typedef struct packed {
    logic [PIN_N-1:0]        s1;
    logic [PIN_N-1:0]        s2;
    pps_state_e              st;
    logic                    started;
    logic                    gate;
    logic                    fast_overcurrent_fault_seen;
    logic                    extl_low;
    logic                    extl_trip;
    logic                    chg;
    logic                    ctrl_dis;
    logic                    ack;
    logic [PW-1:0]           prd;
    logic [PW-1:0]           on_cnt;
    logic [PW-1:0]           smp_cnt;
    logic [TW-1:0]           brin_cnt;
    logic [TW-1:0]           brout_cnt;
    logic [TW-1:0]           extl_cnt;
    logic [TW-1:0]           blank_cnt;
    logic [PRE_FALL_CYC-1:0] ext_dly;
    logic [31:0]             dat;
  } pps_core_s;

  pps_core_s        q;
  pps_core_s        d;
  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] p;
  logic [F_N-1:0]   stb;
  logic [F_N-1:0]   hit;
  logic [F_N-1:0]   trip;
  logic             fault;
  logic             kill;
  logic             term;
  logic             fall;
  logic             supply_undervoltage_lockout;
  logic             bus_req;
  logic [31:0]      status;

  // ************************************************************
  // comparator inputs
  // ************************************************************
  assign pins[PIN_BRIN]  = i_line_above_brin;
  assign pins[PIN_BROUT] = i_line_below_brout;
  assign pins[PIN_START] = i_vcc_above_start;
  assign pins[PIN_SUPPLY_UNDERVOLTAGE_LOCKOUT]  = i_vcc_below_supply_undervoltage_lockout;
  assign pins[PIN_MAINT] = i_vcc_below_maint;
  assign pins[PIN_OV]    = i_aux_above_ov;
  assign pins[PIN_UV]    = i_aux_below_uv;
  assign pins[PIN_EXH]   = i_ext_above_high;
  assign pins[PIN_EXL]   = i_ext_below_low;
  assign pins[PIN_FAST_OVERCURRENT_FAULT]  = i_cs_above_fast_overcurrent_fault;
  assign pins[PIN_SENSE_SHORT_FAULT]  = i_cs_below_sense_short_fault;
  assign pins[PIN_LIM]   = i_cs_above_limit;
  assign pins[PIN_PWM]   = i_pwm_cmp_trip;
  assign pins[PIN_FB]    = i_fb_below_min;
  assign pins[PIN_OTP]   = i_otp_hot;

  assign p       = q.s2;
  assign supply_undervoltage_lockout    = p[PIN_SUPPLY_UNDERVOLTAGE_LOCKOUT];
  assign fault   = (|trip) || q.extl_trip;
  assign bus_req = i_wb_cyc && i_wb_stb;

  // ************************************************************
  // status word
  // ************************************************************
  always_comb begin
    status                   = '0;
    status[STAT_ST +: 2]     = q.st;
    status[STAT_GATE]        = q.gate;
    status[STAT_TRIP +: F_N] = trip;
    status[STAT_EXTL]        = q.extl_trip;
    status[STAT_OTP]         = p[PIN_OTP];
    status[STAT_FB]          = p[PIN_FB];
    status[STAT_START]       = q.started;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d    = q;
    d.s1 = pins;
    d.s2 = q.s1;
    stb  = '0;
    hit  = '0;
    fall = 1'b0;
    kill = (q.st != ST_RUN) || fault || p[PIN_OTP] || q.ctrl_dis; // R16
    term = 1'b0;

    // switching period
    if (q.st == ST_RUN) begin
      d.prd = (q.prd == PW'(PERIOD - 1)) ? '0 : q.prd + 1'b1;
    end else begin
      d.prd = '0;
    end

    // gate drive with leading-edge blanking
    if (q.on_cnt >= PW'(LEB_CYC - 1)) begin // R19
      term = p[PIN_LIM] || p[PIN_PWM]; // R20
    end
    if (q.on_cnt >= PW'(MAXON - 1)) begin
      term = 1'b1;
    end
    if (q.gate) begin
      d.on_cnt = q.on_cnt + 1'b1;
      if (kill || term) begin
        d.gate = 1'b0;
      end
      if (p[PIN_FAST_OVERCURRENT_FAULT]) begin
        d.fast_overcurrent_fault_seen = 1'b1;
      end
    end else if (q.prd == '0 && !kill && !p[PIN_FB]) begin // R17
      d.gate      = 1'b1;
      d.on_cnt    = '0;
      d.fast_overcurrent_fault_seen = 1'b0;
    end
    fall = q.gate && !d.gate;

    // sense-short sample after rise
    stb[F_SENSE_SHORT_FAULT] = q.gate && (q.on_cnt == PW'(SENSE_SHORT_FAULT_CYC)); // R13
    hit[F_SENSE_SHORT_FAULT] = p[PIN_SENSE_SHORT_FAULT]; // R14

    // external pin history before the fall
    d.ext_dly = {q.ext_dly[PRE_FALL_CYC-2:0], p[PIN_EXL]};

    // samples around the gate fall
    if (fall) begin
      stb[F_FAST_OVERCURRENT_FAULT] = 1'b1;
      hit[F_FAST_OVERCURRENT_FAULT] = q.fast_overcurrent_fault_seen || p[PIN_FAST_OVERCURRENT_FAULT]; // R12
      d.extl_low  = q.ext_dly[PRE_FALL_CYC-1]; // R09
      d.smp_cnt   = PW'(1);
    end else if (q.smp_cnt != '0) begin
      if (q.smp_cnt == PW'(TSMP_CYC)) begin
        stb[F_OV]  = 1'b1; // R04
        stb[F_UV]  = 1'b1;
        stb[F_EXH] = 1'b1; // R08
        d.smp_cnt  = '0;
      end else begin
        d.smp_cnt = q.smp_cnt + 1'b1;
      end
    end
    hit[F_OV]  = p[PIN_OV];
    hit[F_UV]  = p[PIN_UV] && (q.blank_cnt == TW'(UVB_CYC)); // R07
    hit[F_EXH] = p[PIN_EXH];

    // startup blank for undervoltage
    if (q.st != ST_RUN) begin
      d.blank_cnt = '0;
    end else if (q.blank_cnt != TW'(UVB_CYC)) begin
      d.blank_cnt = q.blank_cnt + 1'b1;
    end

    // external low duration
    if (q.st == ST_RUN && q.extl_low) begin
      if (q.extl_cnt == TW'(EXTL_CYC - 1)) begin
        d.extl_trip = 1'b1; // R10
      end else begin
        d.extl_cnt = q.extl_cnt + 1'b1;
      end
    end else begin
      d.extl_cnt = '0;
    end

    // line timers
    if (!p[PIN_BRIN]) begin
      d.brin_cnt = '0;
    end else if (q.brin_cnt != TW'(BRIN_CYC)) begin
      d.brin_cnt = q.brin_cnt + 1'b1;
    end
    if (q.st == ST_RUN && p[PIN_BROUT]) begin
      d.brout_cnt = q.brout_cnt + 1'b1;
    end else begin
      d.brout_cnt = '0;
    end

    if (p[PIN_START]) begin
      d.started = 1'b1;
    end
    d.chg = p[PIN_MAINT]; // R18

    // operating state
    case (q.st)
      ST_WAIT: begin
        if (q.brin_cnt == TW'(BRIN_CYC) && q.started) begin // R01
          d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault) begin
          d.st = ST_LATCH; // R11
        end else if (q.brout_cnt == TW'(BROUT_CYC - 1) && p[PIN_BROUT]) begin
          d.st        = ST_BROWN; // R02
          d.brout_cnt = '0;
        end
      end
      ST_BROWN: begin
        if (p[PIN_BRIN]) begin
          d.st = ST_WAIT; // R03
        end
      end
      ST_LATCH: begin
        d.st = ST_LATCH; // R06
      end
      default: begin
        d.st = ST_WAIT;
      end
    endcase

    // supply lockout restarts state, timers, counters and faults; the control register keeps its value
    if (supply_undervoltage_lockout) begin // R22
      d.st        = ST_WAIT;
      d.started   = 1'b0;
      d.gate      = 1'b0;
      d.on_cnt    = '0;
      d.prd       = '0;
      d.smp_cnt   = '0;
      d.fast_overcurrent_fault_seen = 1'b0;
      d.extl_low  = 1'b0;
      d.extl_trip = 1'b0;
      d.brin_cnt  = '0;
      d.brout_cnt = '0;
      d.extl_cnt  = '0;
      d.blank_cnt = '0;
      stb         = '0;
    end

    // wishbone slave, one wait state
    d.ack = bus_req && !q.ack;
    if (bus_req && !q.ack) begin
      case (i_wb_adr)
        REG_CTRL:   d.dat = {31'h0, q.ctrl_dis};
        REG_STATUS: d.dat = status;
        default:    d.dat = '0;
      endcase
    end
    if (bus_req && q.ack && i_wb_we && i_wb_sel[0] && i_wb_adr == REG_CTRL) begin
      d.ctrl_dis = i_wb_dat[CTRL_DIS];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q          <= '0;
      q.ctrl_dis <= CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // consecutive-cycle fault counters
  // ************************************************************
  generate
    for (genvar g = 0; g < F_N; g++) begin : g_cnt
      pps_cyc_cnt #(
        .N (FAULT_CYCLES)
      ) u_cnt (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_clr     (supply_undervoltage_lockout),
        .i_stb     (stb[g]),
        .i_hit     (hit[g]),
        .o_trip    (trip[g])
      ); // R05 R15
    end
  endgenerate

  assign o_gate          = q.gate;
  assign o_vcc_charge_hi = q.chg;
  assign o_wb_ack        = q.ack;
  assign o_wb_dat        = q.dat;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_rise;
    !q.gate ##1 q.gate;
  endsequence
  sequence s_blank_hold;
    !kill [*7];
  endsequence

  leb_hold_a: assert property ((s_rise ##0 s_blank_hold) |=> q.gate) // R20
    else $error("gate ended inside blanking");
  leb_term_a: assert property ((q.gate && q.on_cnt < PW'(LEB_CYC - 1) && !kill) |=> q.gate) // R19
    else $error("pulse terminated before blanking end");
  fb_block_a: assert property ((!q.gate && p[PIN_FB]) |=> !q.gate) // R17
    else $error("pulse started with feedback low");
  otp_block_a: assert property (p[PIN_OTP] |=> !q.gate) // R16
    else $error("gate active during over-temperature");
  idle_off_a: assert property ((q.st != ST_RUN) |=> !q.gate) // R03
    else $error("gate active outside run");
  latch_hold_a: assert property ((q.st == ST_LATCH && !supply_undervoltage_lockout) |=> (q.st == ST_LATCH)) // R06
    else $error("latched fault left without lockout");
  fault_stop_a: assert property ((q.st == ST_RUN && fault && !supply_undervoltage_lockout) |=> (q.st == ST_LATCH)) // R11
    else $error("fault did not latch shutdown");
  brout_a: assert property ((q.st == ST_RUN && !fault && !supply_undervoltage_lockout && p[PIN_BROUT] &&
                             q.brout_cnt == TW'(BROUT_CYC - 1)) |=> (q.st == ST_BROWN)) // R02
    else $error("brown-out not taken");
  supply_undervoltage_lockout_clr_a: assert property (supply_undervoltage_lockout |=> (q.st == ST_WAIT && !q.extl_trip && !q.gate)) // R22
    else $error("lockout did not clear state");
  charge_a: assert property (p[PIN_MAINT] |=> o_vcc_charge_hi) // R18
    else $error("maintain charge not enabled");
endmodule

/* core/pps_pkg.sv */
package pps_pkg;
  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_MHZ      = 100;
  localparam int SW_FREQ_KHZ  = 65;
  localparam int PERIOD_CYC   = (CLK_MHZ * 1000) / SW_FREQ_KHZ;
  localparam int MAX_DUTY_PCT = 75;
  localparam int MAXON_CYC    = (PERIOD_CYC * MAX_DUTY_PCT) / 100;
  localparam int BRIN_US      = 100;
  localparam int BRIN_CYC     = BRIN_US * CLK_MHZ;
  localparam int BROUT_MS     = 50;
  localparam int BROUT_CYC    = BROUT_MS * 1000 * CLK_MHZ;
  localparam int EXTL_MS      = 32;
  localparam int EXTL_CYC     = EXTL_MS * 1000 * CLK_MHZ;
  localparam int UVB_MS       = 10;
  localparam int UVB_CYC      = UVB_MS * 1000 * CLK_MHZ;
  localparam int LEB_NS       = 250;
  localparam int LEB_CYC      = (LEB_NS * CLK_MHZ + 999) / 1000;
  localparam int PRE_FALL_NS  = 100;
  localparam int PRE_FALL_CYC = (PRE_FALL_NS * CLK_MHZ) / 1000;
  localparam int SENSE_SHORT_FAULT_US      = 4;
  localparam int SENSE_SHORT_FAULT_CYC     = SENSE_SHORT_FAULT_US * CLK_MHZ;
  localparam int TSMP_NS      = 2000;
  localparam int TSMP_CYC     = (TSMP_NS * CLK_MHZ) / 1000;
  localparam int FAULT_CYCLES = 7;

  // ************************************************************
  // registers
  // ************************************************************
  localparam int         ADR_W      = 8;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int         CTRL_DIS   = 0;
  localparam logic       CTRL_RST   = 1'h0;
  localparam int         STAT_ST    = 0;
  localparam int         STAT_GATE  = 2;
  localparam int         STAT_TRIP  = 3;
  localparam int         STAT_EXTL  = 8;
  localparam int         STAT_OTP   = 9;
  localparam int         STAT_FB    = 10;
  localparam int         STAT_START = 11;

  // ************************************************************
  // comparator pins and fault indices
  // ************************************************************
  localparam int PIN_BRIN  = 0;
  localparam int PIN_BROUT = 1;
  localparam int PIN_START = 2;
  localparam int PIN_SUPPLY_UNDERVOLTAGE_LOCKOUT  = 3;
  localparam int PIN_MAINT = 4;
  localparam int PIN_OV    = 5;
  localparam int PIN_UV    = 6;
  localparam int PIN_EXH   = 7;
  localparam int PIN_EXL   = 8;
  localparam int PIN_FAST_OVERCURRENT_FAULT  = 9;
  localparam int PIN_SENSE_SHORT_FAULT  = 10;
  localparam int PIN_LIM   = 11;
  localparam int PIN_PWM   = 12;
  localparam int PIN_FB    = 13;
  localparam int PIN_OTP   = 14;
  localparam int PIN_N     = 15;
  localparam int F_OV      = 0;
  localparam int F_UV      = 1;
  localparam int F_EXH     = 2;
  localparam int F_FAST_OVERCURRENT_FAULT    = 3;
  localparam int F_SENSE_SHORT_FAULT    = 4;
  localparam int F_N       = 5;

  typedef enum logic [1:0] {
    ST_WAIT  = 2'b00,
    ST_RUN   = 2'b01,
    ST_BROWN = 2'b10,
    ST_LATCH = 2'b11
  } pps_state_e;
endpackage

/* core/pps_cyc_cnt.sv */
`timescale 1ns/10ps
module pps_cyc_cnt #(
  parameter int N = pps_pkg::FAULT_CYCLES
) (
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  input  wire logic i_clr,
  input  wire logic i_stb,
  input  wire logic i_hit,
  output logic      o_trip
);
  import pps_pkg::*;
  localparam int W = $clog2(N + 1);

  generate
    if (N < 1) begin : g_chk
      $error("pps_cyc_cnt: N must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         trip;
  } pps_cnt_s;

  pps_cnt_s q;
  pps_cnt_s d;

  // ************************************************************
  // consecutive cycle count
  // ************************************************************
  always_comb begin
    d = q;
    if (i_clr) begin
      d = '0; // R22
    end else if (i_stb && !q.trip) begin
      if (!i_hit) begin
        d.cnt = '0; // R21
      end else if (q.cnt == W'(N - 1)) begin
        d.trip = 1'b1;
        d.cnt  = W'(N);
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_trip = q.trip;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  cnt_trip_a: assert property ((q.cnt == W'(N - 1) && i_stb && i_hit && !i_clr) |=> o_trip) // R05
    else $error("trip missed on last consecutive hit");
  cnt_miss_a: assert property ((i_stb && !i_hit && !i_clr && !q.trip) |=> (q.cnt == '0 && !o_trip)) // R21
    else $error("count not cleared on a miss");
  cnt_hold_a: assert property ((o_trip && !i_clr) |=> o_trip) // R22
    else $error("trip released without lockout");
endmodule

/* dv/pps_afe_model.sv */
`timescale 1ns/10ps
// ************************************************************
// analog front end and power stage stand-in
// ************************************************************
module pps_afe_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_gate,
  input  wire logic       i_line_ok,
  input  wire logic       i_lim_early,
  input  wire logic [3:0] i_lvl,
  input  wire logic [7:0] i_on_t,
  output logic            o_above_brin,
  output logic            o_below_brout,
  output logic            o_above_ov,
  output logic            o_below_uv,
  output logic            o_ext_high,
  output logic            o_fast_overcurrent_fault,
  output logic            o_limit,
  output logic            o_pwm_trip
);
  int on_cnt = 0;

  // primary current ramp, zero while switch is off
  always @(posedge i_ref_clk) begin
    on_cnt <= i_gate ? on_cnt + 1 : 0;
  end

  assign o_above_brin  = i_line_ok;
  assign o_below_brout = ~i_line_ok;
  assign o_above_ov    = i_lvl[0];
  assign o_below_uv    = i_lvl[1];
  assign o_ext_high    = i_lvl[2];
  assign o_fast_overcurrent_fault        = i_gate & i_lvl[3];
  assign o_limit       = i_gate & i_lim_early;
  // on time of all ones: comparator never ends the pulse, max on time does
  assign o_pwm_trip    = i_gate && (i_on_t != 8'hFF) && (on_cnt >= int'(i_on_t));
endmodule

/* dv/pwm_protection_supervisor_bench.sv */
`timescale 1ns/10ps
module pwm_protection_supervisor_bench;
  import pps_pkg::*;
  localparam int BRIN = 20;
  localparam int BROUT = 50;
  localparam int PRD = 500;
  logic        clk = 0, nrst = 0, start = 0, supply_undervoltage_lockout = 0, maint = 0, fb = 0, otp = 0;
  logic        line_ok = 0, lim = 0, cyc = 0, stb = 0, we = 0, gate, chg, ack;
  logic        brin, brout, ov, uv, exh, fast_overcurrent_fault, limc, pwm;
  logic        extl = 0, sense_short_fault = 0;
  logic [3:0]  lvl = 4'h0;
  logic [4:0]  exp_trip = 5'h00;
  logic [7:0]  adr = 8'h00, on_t = 8'h40;
  logic [31:0] wdat = 32'h0, rdat, q;
  int          error_cnt = 0, checked = 0, pulses = 0, hw = 0, last_w = 0, exp_state = 0;
  int          n, p;
  int          seed = 32'h6F7F95D4;

  always #5 clk = ~clk;

  pps_afe_model afe (.i_ref_clk(clk), .i_gate(gate), .i_line_ok(line_ok), .i_lim_early(lim),
    .i_lvl(lvl), .i_on_t(on_t), .o_above_brin(brin), .o_below_brout(brout), .o_above_ov(ov),
    .o_below_uv(uv), .o_ext_high(exh), .o_fast_overcurrent_fault(fast_overcurrent_fault), .o_limit(limc), .o_pwm_trip(pwm));

  pps_supervisor #(.BRIN_CYC(BRIN), .BROUT_CYC(BROUT), .EXTL_CYC(40), .UVB_CYC(30),
    .PERIOD(PRD), .MAXON(450)) uut (.i_ref_clk(clk), .i_nrst(nrst),
    .i_line_above_brin(brin), .i_line_below_brout(brout), .i_vcc_above_start(start),
    .i_vcc_below_supply_undervoltage_lockout(supply_undervoltage_lockout), .i_vcc_below_maint(maint), .i_aux_above_ov(ov),
    .i_aux_below_uv(uv), .i_ext_above_high(exh), .i_ext_below_low(extl),
    .i_cs_above_fast_overcurrent_fault(fast_overcurrent_fault), .i_cs_below_sense_short_fault(sense_short_fault), .i_cs_above_limit(limc),
    .i_pwm_cmp_trip(pwm), .i_fb_below_min(fb), .i_otp_hot(otp), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_gate(gate), .o_vcc_charge_hi(chg));

  // ************************************************************
  // gate pulse counting and width
  // ************************************************************
  always @(posedge gate) pulses++;
  always @(posedge clk) begin
    if (gate) hw <= hw + 1;
    else if (hw != 0) begin
      last_w <= hw;
      hw <= 0;
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic clks(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'h1 && k < 50);
    chk("wb_ack", 1, 32'(k < 50));
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    @(posedge clk);
  endtask

  task automatic status_chk;
    wb(1'h0, REG_STATUS, 32'h0);
    chk("state", 32'(exp_state), 32'(q[1:0]));
    chk("trips", 32'(exp_trip), 32'(q[7:3]));
  endtask

  task automatic lockout;
    supply_undervoltage_lockout <= 1'h1;
    start <= 1'h0;
    line_ok <= 1'h0;
    lvl <= 4'h0;
    clks(6);
    supply_undervoltage_lockout <= 1'h0;
    clks(4);
    exp_state = 0;
    exp_trip = 5'h00;
  endtask

  task automatic boot;
    on_t <= 8'(40 + ($random(seed) & 63));
    start <= 1'h1;
    line_ok <= 1'h1;
    n = 0;
    while (gate !== 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("brin_min", 1, 32'(n >= BRIN));
    chk("brin_max", 1, 32'(n <= BRIN + 10));
    exp_state = 1;
  endtask

  task automatic fall250;
    @(negedge gate);
    clks(250);
  endtask

  task automatic hits(input int f, input int k);
    lvl[f] <= 1'h1;
    repeat (k) fall250;
    lvl[f] <= 1'h0;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    clks(2);
    chk("rst_gate", 0, 32'(gate));
    nrst <= 1'h1;
    clks(2);
    status_chk;
    wb(1'h1, 8'h10, 32'hFFFFFFFF);
    wb(1'h0, 8'h10, 32'h0);
    chk("unmapped", 0, q);
    wb(1'h0, REG_CTRL, 32'h0);
    chk("ctrl_rst", 0, q);
    $display("test reset done");
    for (int f = 0; f < 4; f++) begin
      boot;
      fall250;
      hits(f, 6);
      fall250;
      hits(f, 6);
      status_chk;
      hits(f, 1);
      exp_state = 3;
      exp_trip[f] = 1'h1;
      status_chk;
      p = pulses;
      clks(2 * PRD);
      chk("latched", p, pulses);
      lockout;
      status_chk;
      $display("test fault %0d done", f);
    end
    boot;
    line_ok <= 1'h0;
    clks(BROUT - 10);
    line_ok <= 1'h1;
    clks(20);
    status_chk;
    line_ok <= 1'h0;
    clks(BROUT + 10);
    exp_state = 2;
    status_chk;
    p = pulses;
    clks(2 * PRD);
    chk("brown_off", p, pulses);
    boot;
    $display("test brown-out done");
    for (int b = 0; b < 3; b++) begin
      otp <= (b == 0);
      fb <= (b == 1);
      if (b == 2) wb(1'h1, REG_CTRL, $random(seed) | 1);
      clks(PRD);
      p = pulses;
      clks(2 * PRD);
      chk("blocked", p, pulses);
      status_chk;
      otp <= 1'h0;
      fb <= 1'h0;
      wb(1'h1, REG_CTRL, 32'h0);
      p = pulses;
      clks(PRD + 10);
      chk("resumed", 1, 32'(pulses > p));
    end
    $display("test blocking done");
    lim <= 1'h1;
    fall250;
    fall250;
    chk("leb_min", 1, 32'(last_w >= LEB_CYC));
    chk("leb_max", 1, 32'(last_w <= LEB_CYC + 5));
    lim <= 1'h0;
    $display("test blanking done");
    maint <= 1'h1;
    clks(4);
    chk("charge_on", 1, 32'(chg));
    maint <= 1'h0;
    clks(4);
    chk("charge_off", 0, 32'(chg));
    $display("test maintain done");
    lockout;
    for (int s = 0; s < 2; s++) begin
      boot;
      if (s == 1) on_t <= 8'hFF;
      extl <= (s == 0);
      sense_short_fault <= (s == 1);
      clks(8 * PRD);
      extl <= 1'h0;
      sense_short_fault <= 1'h0;
      exp_state = 3;
      exp_trip[4] = (s == 1);
      status_chk;
      chk("ext_low", 32'(s == 0), 32'(q[8]));
      lockout;
      status_chk;
    end
    $display("test ext-low and sense-short done");
    end_sim;
  end

  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    $display("BAD watchdog exp done got hang");
    end_sim;
  end
endmodule
